// ---- holdover_pkg.sv ----
// constants and types for the pll holdover controller
// Contract
// [R1] holdover only tri-states charge pump; no up or down current while held
// [R2] holdover enable bit clear disables both manual and automatic holdover
// [R3] manual holdover enters on falling edge of align pin, not low level
// [R4] after align pin high, release only at next reference pfd edge
// [R5] b counter reset on same pfd event that ends holdover; prescaler kept
// [R6] each of four channels has ignore-align bit; clear means low stops outputs
// [R7] automatic holdover enters when sensed lock pin shows lost lock
// [R8] comparator enable off makes lock pin read as permanently high
// [R9] automatic holdover holds while no reference edge reaches the pfd
// [R10] no automatic re-entry until lock regained and lock pin charged high
// [R11] automatic holdover tracks selected reference; switchover loss ends next edge
// [R12] lock detect counter field sets consecutive in-window cycles; 00b is five
// [R13] software keeps digital lock detect disable bit at zero
// [R14] lock pin control 000100b selects charged lock detect mode
// [R15] external holdover bit zero selects automatic, disables manual holdover
// [R16] reference control: auto switchover, preferred reference, both buffers
// [R17] lock window bit zero selects high-range window
// [R18] external clock input is distribution-only or pll feedback source
// [R19] users should run lock indicator in current-source mode
// [R20] digital lock flag sets after n good cycles, clears on one bad cycle
// [R21] charged mode sources current while flag true, grounds pin when false
// [R22] align pin and comparator output synchronised before use
`default_nettype none
package holdover_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------
    localparam logic [11:0] ADDR_LOCK_CFG  = 12'h060;
    localparam logic [11:0] ADDR_LDPIN_CFG = 12'h068;
    localparam logic [11:0] ADDR_REF_CFG   = 12'h070;
    localparam logic [11:0] ADDR_HOLD_CFG  = 12'h074;
    localparam logic [11:0] ADDR_CHAN_CFG  = 12'h644;
    localparam logic [11:0] ADDR_STATUS    = 12'h800;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int LDC_LO     = 5;
    localparam int LDWIN_BIT  = 4;
    localparam int DLDDIS_BIT = 3;
    localparam int EXTCLK_BIT = 0;
    localparam int AUTOSW_BIT = 4;
    localparam int PREF_BIT   = 3;
    localparam int BUF_LO     = 1;
    localparam int CMPEN_BIT  = 3;
    localparam int EXTHO_BIT  = 1;
    localparam int HOEN_BIT   = 0;
    localparam logic [5:0] LDPIN_CHARGED = 6'h04;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] LOCK_CFG_RST  = 8'h00;
    localparam logic [7:0] LDPIN_CFG_RST = 8'h00;
    localparam logic [7:0] REF_CFG_RST   = 8'h00;
    localparam logic [7:0] HOLD_CFG_RST  = 8'h00;
    localparam logic [3:0] CHAN_CFG_RST  = 4'h0;
    localparam int NUM_CHAN = 4;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        HO_IDLE,
        HO_HELD,
        HO_RELEASE,
        HO_REARM
    } ho_state_t;

    // lock counter code to required good cycles
    function automatic logic [4:0] lock_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: lock_cycles = 5'h05;
            2'h1: lock_cycles = 5'h10;
            2'h2: lock_cycles = 5'h10;
            2'h3: lock_cycles = 5'h1F;
        endcase
    endfunction : lock_cycles
endpackage : holdover_pkg
`default_nettype wire

// ---- sync2.sv ----
// two-flop level synchroniser
`default_nettype none
module sync2 (
    input  wire logic clock_in,
    input  wire logic resetn_in,
    input  wire logic rst_val_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            meta_q <= rst_val_in;
            sync_q <= rst_val_in;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end
    assign q_out = sync_q;
endmodule : sync2
`default_nettype wire

// ---- lock_detect.sv ----
// digital lock flag counter
`default_nettype none
module lock_detect
    import holdover_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic       disable_in,
    input  wire logic [1:0] count_sel_in,
    input  wire logic       pfd_event_in,
    input  wire logic       in_lock_win_in,
    input  wire logic       in_unlock_win_in,
    output logic            lock_out
);
    logic [4:0] good_q;
    logic       lock_q;
    // [R20] set after n good, clear on one bad
    always_ff @(posedge clock_in) begin
        if (!resetn_in || disable_in) begin
            good_q <= 5'h00;
            lock_q <= 1'b0;
        end else if (pfd_event_in) begin
            if (!in_lock_win_in)
                good_q <= 5'h00;
            else if (good_q != 5'h1F)
                good_q <= good_q + 5'h01;
            // [R12] programmed count
            if (in_lock_win_in && (good_q + 5'h01) >= lock_cycles(count_sel_in))
                lock_q <= 1'b1;
            else if (!in_unlock_win_in)
                lock_q <= 1'b0;
        end
    end
    assign lock_out = lock_q;
endmodule : lock_detect
`default_nettype wire

// ---- pll_holdover_controller.sv ----
// holdover control, lock detect and configuration registers
`default_nettype none
module pll_holdover_controller
    import holdover_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic [11:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        align_n_in,
    input  wire logic        lock_cmp_in,
    input  wire logic        pfd_ref_edge_in,
    input  wire logic        ref_present_in,
    input  wire logic        in_lock_win_in,
    input  wire logic        in_unlock_win_in,
    output logic             cp_hiz_out,
    output logic             b_counter_reset_out,
    output logic [3:0]       chan_stop_out,
    output logic             lock_pin_source_out,
    output logic             lock_pin_oe_n_out,
    output logic             digital_lock_flag_out,
    output logic             auto_switch_out,
    output logic             ref_select_out,
    output logic [1:0]       ref_buf_en_out,
    output logic             high_range_win_out,
    output logic             ext_clk_feedback_out
);
    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    logic [7:0] lock_cfg_q;
    logic [7:0] ldpin_cfg_q;
    logic [7:0] ref_cfg_q;
    logic [7:0] hold_cfg_q;
    logic [3:0] chan_cfg_q;
    logic       rd_pend_q;
    logic [31:0] rdata_q;
    logic       wr_en;
    assign wr_en = avs_write_in && avs_byteenable_in[0];

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            lock_cfg_q  <= LOCK_CFG_RST;
            ldpin_cfg_q <= LDPIN_CFG_RST;
            ref_cfg_q   <= REF_CFG_RST;
            hold_cfg_q  <= HOLD_CFG_RST;
            chan_cfg_q  <= CHAN_CFG_RST;
        end else if (wr_en) begin
            unique case (avs_address_in)
                ADDR_LOCK_CFG:  lock_cfg_q  <= avs_writedata_in[7:0];
                ADDR_LDPIN_CFG: ldpin_cfg_q <= {2'h0, avs_writedata_in[5:0]};
                ADDR_REF_CFG:   ref_cfg_q   <= avs_writedata_in[7:0];
                ADDR_HOLD_CFG:  hold_cfg_q  <= avs_writedata_in[7:0];
                ADDR_CHAN_CFG:  chan_cfg_q  <= avs_writedata_in[3:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // synchronisers and lock detect
    // -------------------------------------------------------------
    logic align_n_s;
    logic cmp_s;
    logic digital_lock_flag;
    // [R22] align pin into pfd domain
    sync2 u_sync_align (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .rst_val_in (1'b1),
        .d_in       (align_n_in),
        .q_out      (align_n_s)
    );
    // [R22] comparator into pfd domain
    sync2 u_sync_cmp (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .rst_val_in (1'b1),
        .d_in       (lock_cmp_in),
        .q_out      (cmp_s)
    );
    lock_detect u_lock (
        .clock_in         (clock_in),
        .resetn_in        (resetn_in),
        .disable_in       (lock_cfg_q[DLDDIS_BIT]),
        .count_sel_in     (lock_cfg_q[LDC_LO +: 2]),
        .pfd_event_in     (pfd_ref_edge_in),
        .in_lock_win_in   (in_lock_win_in),
        .in_unlock_win_in (in_unlock_win_in),
        .lock_out         (digital_lock_flag)
    );

    // -------------------------------------------------------------
    // holdover state machine
    // -------------------------------------------------------------
    logic      align_prev_q;
    ho_state_t state_q;
    logic      hiz_q;
    logic      brst_q;
    logic      ld_sense;
    logic      ho_en;
    logic      manual;
    logic      align_fall;
    // [R8] disabled comparator reads high
    assign ld_sense   = hold_cfg_q[CMPEN_BIT] ? cmp_s : 1'b1;
    // [R2] master enable
    assign ho_en      = hold_cfg_q[HOEN_BIT];
    // [R15] mode select
    assign manual     = hold_cfg_q[EXTHO_BIT];
    // [R3] edge, not level
    assign align_fall = align_prev_q && !align_n_s;

    always_ff @(posedge clock_in) begin
        if (!resetn_in)
            align_prev_q <= 1'b1;
        else
            align_prev_q <= align_n_s;
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_q <= HO_IDLE;
            hiz_q   <= 1'b0;
            brst_q  <= 1'b0;
        end else if (!ho_en) begin
            state_q <= HO_IDLE;
            hiz_q   <= 1'b0;
            brst_q  <= 1'b0;
        end else begin
            brst_q <= 1'b0;
            unique case (state_q)
                HO_IDLE: begin
                    // [R3] manual entry
                    if (manual && align_fall) begin
                        state_q <= HO_HELD;
                        hiz_q   <= 1'b1;
                    // [R7] automatic entry on lost lock
                    end else if (!manual && !ld_sense) begin
                        state_q <= HO_HELD;
                        hiz_q   <= 1'b1;
                    end
                end
                HO_HELD: begin
                    // [R4] [R9] [R11] leave only on reference edge
                    if (pfd_ref_edge_in && (manual ? align_n_s : 1'b1)) begin
                        hiz_q   <= 1'b0;
                        // [R5] b counter reset with release
                        brst_q  <= 1'b1;
                        state_q <= manual ? HO_IDLE : HO_REARM;
                    end
                end
                HO_REARM: begin
                    // [R10] wait for relock and charged pin
                    if (digital_lock_flag && ld_sense)
                        state_q <= HO_IDLE;
                end
                HO_RELEASE: state_q <= HO_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    logic [3:0] chan_stop_q;
    logic       charged;
    // [R14] charged lock detect mode code
    assign charged = ldpin_cfg_q[5:0] == LDPIN_CHARGED;
    always_ff @(posedge clock_in) begin
        if (!resetn_in)
            chan_stop_q <= 4'h0;
        else
            // [R6] per channel ignore-align
            chan_stop_q <= ~chan_cfg_q & {NUM_CHAN{~align_n_s}};
    end
    // [R1] tri-state pump only
    assign cp_hiz_out            = hiz_q;
    assign b_counter_reset_out   = brst_q;
    assign chan_stop_out         = chan_stop_q;
    // [R21] source when flag true, ground otherwise
    assign lock_pin_source_out   = charged && digital_lock_flag;
    assign lock_pin_oe_n_out     = !(charged && !digital_lock_flag);
    assign digital_lock_flag_out = digital_lock_flag;
    // [R16] reference controls
    assign auto_switch_out       = ref_cfg_q[AUTOSW_BIT];
    assign ref_select_out        = ref_cfg_q[PREF_BIT];
    assign ref_buf_en_out        = ref_cfg_q[BUF_LO +: 2];
    // [R17] zero is high range
    assign high_range_win_out    = !lock_cfg_q[LDWIN_BIT];
    // [R18] external clock role
    assign ext_clk_feedback_out  = ref_cfg_q[EXTCLK_BIT];

    // -------------------------------------------------------------
    // avalon read path, one wait state on reads
    // -------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            rd_pend_q <= 1'b0;
            rdata_q   <= RDATA_ZERO;
        end else begin
            rd_pend_q <= avs_read_in && !rd_pend_q;
            unique case (avs_address_in)
                ADDR_LOCK_CFG:  rdata_q <= {24'h0, lock_cfg_q};
                ADDR_LDPIN_CFG: rdata_q <= {24'h0, ldpin_cfg_q};
                ADDR_REF_CFG:   rdata_q <= {24'h0, ref_cfg_q};
                ADDR_HOLD_CFG:  rdata_q <= {24'h0, hold_cfg_q};
                ADDR_CHAN_CFG:  rdata_q <= {28'h0, chan_cfg_q};
                ADDR_STATUS:    rdata_q <= {26'h0, ref_present_in, ld_sense,
                                            digital_lock_flag, brst_q, hiz_q, 1'b0};
                default:        rdata_q <= RDATA_ZERO;
            endcase
        end
    end
    assign avs_waitrequest_out = avs_read_in && !rd_pend_q;
    assign avs_readdata_out    = rdata_q;
endmodule : pll_holdover_controller
`default_nettype wire

// ---- holdover_chk.sv ----
// port-level checker for the pll holdover controller
`default_nettype none
module holdover_chk (
    input wire logic       clock_in,
    input wire logic       resetn_in,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic       align_n_in,
    input wire logic       pfd_ref_edge_in,
    input wire logic       in_lock_win_in,
    input wire logic       in_unlock_win_in,
    input wire logic       cp_hiz_out,
    input wire logic       b_counter_reset_out,
    input wire logic [3:0] chan_stop_out,
    input wire logic       lock_pin_source_out,
    input wire logic       lock_pin_oe_n_out,
    input wire logic       digital_lock_flag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // ------------------------------------------
    // assertions
    // ------------------------------------------
    AST_B_PULSE: assert property (b_counter_reset_out |=>
        !b_counter_reset_out) else $error("b reset too long");
    AST_B_WITH_EXIT: assert property (b_counter_reset_out |->
        !cp_hiz_out && $past(cp_hiz_out)) else $error("b reset off exit");
    AST_EXIT_ON_EDGE: assert property (b_counter_reset_out |->
        $past(pfd_ref_edge_in)) else $error("exit without pfd edge");
    // a register write may drop holdover, so exclude it
    AST_HOLD_NO_REF: assert property (cp_hiz_out && !pfd_ref_edge_in
        && !avs_write_in && !$past(avs_write_in) |=> cp_hiz_out)
        else $error("holdover left without pfd edge");
    AST_FLAG_DROP: assert property (digital_lock_flag_out
        && pfd_ref_edge_in && !in_unlock_win_in |=> !digital_lock_flag_out)
        else $error("lock flag kept after bad cycle");
    AST_FLAG_RISE: assert property ($rose(digital_lock_flag_out) |->
        $past(pfd_ref_edge_in && in_lock_win_in))
        else $error("lock flag rose without good edge");
    AST_SRC_FLAG: assert property (lock_pin_source_out |->
        digital_lock_flag_out) else $error("pin sourced while unlocked");
    AST_GND_FLAG: assert property (!lock_pin_oe_n_out |->
        !digital_lock_flag_out && !lock_pin_source_out)
        else $error("pin grounded while locked");
    AST_READ_WAIT: assert property (avs_read_in && !$past(avs_read_in)
        |-> avs_waitrequest_out) else $error("read without wait state");
    AST_WRITE_NOWAIT: assert property (avs_write_in |->
        !avs_waitrequest_out) else $error("write stalled");
    AST_CHAN_IDLE: assert property (align_n_in [*6] |->
        chan_stop_out == 4'h0) else $error("channel stopped, align high");
endmodule : holdover_chk
bind pll_holdover_controller holdover_chk chk (.clock_in, .resetn_in,
    .avs_read_in, .avs_write_in, .avs_waitrequest_out, .align_n_in,
    .pfd_ref_edge_in, .in_lock_win_in, .in_unlock_win_in, .cp_hiz_out,
    .b_counter_reset_out, .chan_stop_out, .lock_pin_source_out,
    .lock_pin_oe_n_out, .digital_lock_flag_out);
`default_nettype wire

// ---- pll_far_side.sv ----
// behavioural far side: pfd events, lock windows, lock pin capacitor
`default_nettype none
module pll_far_side (
    input  wire logic clock_in,
    input  wire logic run_ref_in,
    input  wire logic good_in,
    input  wire logic lock_pin_source_in,
    input  wire logic lock_pin_oe_n_in,
    output logic      pfd_ref_edge_out,
    output logic      in_lock_win_out,
    output logic      in_unlock_win_out,
    output logic      lock_cmp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q = 2'h0;
    logic [4:0] cap_q = 5'h00;
    // one pfd event every four clocks, none while the reference is gone
    always @(posedge clock_in) begin
        div_q <= div_q + 2'h1;
        pfd_ref_edge_out <= run_ref_in && div_q == 2'h3;
        in_lock_win_out <= good_in;
        in_unlock_win_out <= good_in;
    end
    // pin capacitor model: instant discharge, slow charge
    always @(posedge clock_in) begin
        if (!lock_pin_oe_n_in)
            cap_q <= 5'h00;
        else if (lock_pin_source_in && cap_q != 5'h1F)
            cap_q <= cap_q + 5'h01;
    end
    assign lock_cmp_out = cap_q > 5'h0F;
endmodule : pll_far_side
`default_nettype wire

// ---- pll_holdover_controller_tb.sv ----
// self-checking bench for the pll holdover controller
`default_nettype none
module pll_holdover_controller_tb import holdover_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in = 1'b0, resetn_in = 1'b0, align_n_in = 1'b1;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0, run_ref = 1'b0;
    logic good = 1'b0;
    logic [11:0] avs_address_in = 12'h000;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic [3:0]  avs_byteenable_in = 4'h0, chan_stop_out, ign;
    logic [1:0]  ref_buf_en_out;
    logic avs_waitrequest_out, cp_hiz_out, b_counter_reset_out;
    logic lock_pin_source_out, lock_pin_oe_n_out, digital_lock_flag_out;
    logic auto_switch_out, ref_select_out, high_range_win_out;
    logic ext_clk_feedback_out, pfd_ref_edge_in, in_lock_win_in;
    logic in_unlock_win_in, lock_cmp_in;
    int bad_count = 0, check_count = 0, n, seed = 99338;
    logic [31:0] exp_q[$];
    pll_holdover_controller uut (.clock_in, .resetn_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .align_n_in, .lock_cmp_in,
        .pfd_ref_edge_in, .ref_present_in(run_ref), .in_lock_win_in,
        .in_unlock_win_in, .cp_hiz_out, .b_counter_reset_out, .chan_stop_out,
        .lock_pin_source_out, .lock_pin_oe_n_out, .digital_lock_flag_out,
        .auto_switch_out, .ref_select_out, .ref_buf_en_out,
        .high_range_win_out, .ext_clk_feedback_out);
    pll_far_side far (.clock_in, .run_ref_in(run_ref), .good_in(good),
        .lock_pin_source_in(lock_pin_source_out),
        .lock_pin_oe_n_in(lock_pin_oe_n_out), .pfd_ref_edge_out(pfd_ref_edge_in),
        .in_lock_win_out(in_lock_win_in), .in_unlock_win_out(in_unlock_win_in),
        .lock_cmp_out(lock_cmp_in));
    always #4 clock_in = ~clock_in;
    // ------------------------------------------
    // tasks
    // ------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic [11:0] a, input logic [31:0] d,
                       input logic rd);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= 4'h1;
        avs_read_in <= rd;
        avs_write_in <= !rd;
        do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clock_in);
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 32'h0, 1'b1);
    endtask : rd
    task automatic wait_b;
        for (n = 0; n < 40 && b_counter_reset_out !== 1'b1; n++)
            @(posedge clock_in);
        chk(32'(b_counter_reset_out), 32'h1);
        chk(32'(cp_hiz_out), 32'h0);
    endtask : wait_b
    // read data compared at the edge that completes the read
    always @(posedge clock_in)
        if (avs_read_in && avs_waitrequest_out === 1'b0)
            chk(avs_readdata_out, exp_q.pop_front());
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        rd(ADDR_LOCK_CFG, 32'h0);
        rd(ADDR_HOLD_CFG, 32'h0);
        rd(12'h7FC, 32'h0);
        bus(ADDR_REF_CFG, 32'h16, 1'b0);
        chk({auto_switch_out, ref_select_out, ref_buf_en_out}, 32'hB);
        rd(ADDR_REF_CFG, 32'h16);
        bus(ADDR_REF_CFG, 32'h09, 1'b0);
        chk({ext_clk_feedback_out, ref_select_out}, 32'h3);
        bus(ADDR_LOCK_CFG, 32'h10, 1'b0);
        chk(32'(high_range_win_out), 32'h0);
        bus(ADDR_LOCK_CFG, 32'h00, 1'b0);
        chk(32'(high_range_win_out), 32'h1);
        ign = 4'($random(seed));
        bus(ADDR_CHAN_CFG, 32'(ign), 1'b0);
        align_n_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        chk(32'(chan_stop_out), 32'(4'(~ign)));
        chk(32'(cp_hiz_out), 32'h0);
        bus(ADDR_HOLD_CFG, 32'h03, 1'b0);
        repeat (6) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h0);
        align_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        align_n_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h1);
        align_n_in <= 1'b1;
        repeat (20) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h1);
        run_ref <= 1'b1;
        wait_b();
        // charged mode so the flag charges the lock pin capacitor that the comparator senses
        bus(ADDR_LDPIN_CFG, 32'(LDPIN_CHARGED), 1'b0);
        good <= 1'b1;
        n = 0;
        repeat (200) begin
            @(posedge clock_in);
            if (digital_lock_flag_out === 1'b1) break;
            if (pfd_ref_edge_in && in_lock_win_in) n++;
        end
        chk(n, 5);
        repeat (40) @(posedge clock_in);
        chk({lock_pin_source_out, lock_cmp_in}, 32'h3);
        bus(ADDR_HOLD_CFG, 32'h09, 1'b0);
        align_n_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h0);
        align_n_in <= 1'b1;
        good <= 1'b0;
        for (n = 0; n < 99 && digital_lock_flag_out; n++) @(posedge clock_in);
        run_ref <= 1'b0;
        repeat (10) @(posedge clock_in);
        chk({cp_hiz_out, lock_pin_oe_n_out}, 32'h2);
        rd(ADDR_STATUS, 32'h2);
        repeat (20) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h1);
        run_ref <= 1'b1;
        wait_b();
        repeat (30) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h0);
        bus(ADDR_HOLD_CFG, 32'h01, 1'b0);
        repeat (10) @(posedge clock_in);
        chk(32'(cp_hiz_out), 32'h0);
        end_sim();
    end
endmodule : pll_holdover_controller_tb
`default_nettype wire
